// >>> rtl/qup_pkg.sv
// Package for the quad serial controller host strobe and modem pin block
package qup_pkg;
    // ==========================================
    // Channel and bus sizes
    localparam int NUM_CH = 4;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    // ==========================================
    // Register offsets within a channel (low three address bits)
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_ISR = 3'h2;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_MSR = 3'h6;
    // ==========================================
    // Field positions
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_INTEN_BIT = 3;
    localparam int MCR_AUTORTS_BIT = 5;
    localparam int IER_MODEM_BIT = 3;
    localparam int MSR_RING_DELTA_BIT = 2;
    localparam int MSR_RING_BIT = 6;
    // ==========================================
    // Reset values
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] MCR_RESET = 8'h00;
    // Interrupt status: no interrupt pending / modem status pending
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] ISR_MODEM = 8'h00;
    // Bus access phases, Gray coded
    typedef enum logic [1:0] {
        QUP_IDLE = 2'b00,
        QUP_ACCESS = 2'b01,
        QUP_DONE = 2'b11
    } qup_phase_t;
endpackage

// >>> rtl/qup_strobe_modem.sv
// Host strobe decoding, shared interrupt and modem pins for four channels
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Separate mode: write strobe fall stores data
// R2 - Combined mode: write pin is direction select
// R3 - Host holds select high read, low write
// R4 - Combined mode merges four channel interrupts
// R5 - Combined mode: request low when enabled source needs service
// R6 - Combined mode request only pulls low
// R7 - Channel status readable via upper address
// R8 - Separate mode: pin is channel A interrupt
// R9 - Separate mode: high reset clears everything
// R10 - Reset disables transmit, ignores receive
// R11 - Combined mode: reset input active low
// R12 - Low ring input shows ringing in status
// R13 - Ring rising edge raises interrupt condition
// R14 - Control bit 1 one drives request low
// R15 - Request-to-send high after reset
// R16 - Request affects flow only when auto enabled
// R17 - Separate mode: read strobe fall drives data
// R18 - Separate mode interrupts need control bit 3
// R19 - Combined access only with select low, stable
module qup_strobe_modem
    import qup_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic mode_separate,
    input wire logic reset_pin,
    input wire logic chip_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [NUM_CH-1:0] ring_indicator_n,
    input wire logic [NUM_CH-1:0] rx_in,
    input wire logic [NUM_CH-1:0] rx_fifo_full,
    output logic [NUM_CH-1:0] rts_n,
    output logic [NUM_CH-1:0] tx_enable,
    output logic [NUM_CH-1:0] rx_accept,
    output logic irq_out,
    output logic irq_oe,
    output logic [NUM_CH-1:0] channel_interrupt
);
    // ==========================================
    // State
    typedef struct packed {
        qup_phase_t phase;
        logic wr_prev;
        logic rd_prev;
        logic [NUM_CH-1:0] ring_prev;
        logic [NUM_CH-1:0] ring_delta;
        logic [NUM_CH-1:0][7:0] interrupt_enable_reg;
        logic [NUM_CH-1:0][7:0] modem_control_reg;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic [NUM_CH-1:0] rts_n;
        logic [NUM_CH-1:0] txen;
        logic [NUM_CH-1:0] rxacc;
        logic irq;
        logic irqoe;
        logic [NUM_CH-1:0] chint;
    } qup_state_t;

    qup_state_t st;
    qup_state_t next_st;
    logic pin_reset;
    logic [1:0] ch;
    logic [NUM_CH-1:0] pend;
    logic wr_fall;
    logic rd_fall;
    logic cmb_rd;
    logic cmb_wr;

    // ==========================================
    // Reset pin polarity follows the bus mode
    assign pin_reset = mode_separate ? reset_pin : ~reset_pin; // R9 R11
    assign ch = addr[4:3]; // R7
    assign wr_fall = st.wr_prev & ~io_write_strobe_n; // R1
    assign rd_fall = st.rd_prev & ~io_read_strobe_n; // R17
    // Combined mode: one access per chip select assertion, direction from write pin
    assign cmb_rd = ~mode_separate & ~chip_select_n & io_write_strobe_n
        & (st.phase == QUP_IDLE); // R2 R3 R19
    assign cmb_wr = ~mode_separate & ~chip_select_n & ~io_write_strobe_n
        & (st.phase == QUP_IDLE); // R2 R3 R19

    // Channel needs service: enabled modem status change pending
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            pend[i] = st.ring_delta[i] & st.interrupt_enable_reg[i][IER_MODEM_BIT]; // R5
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        logic do_wr;
        logic do_rd;
        logic [7:0] rd_val;
        do_wr = 1'b0;
        do_rd = 1'b0;
        rd_val = 8'h00;
        next_st = st;
        next_st.wr_prev = io_write_strobe_n;
        next_st.rd_prev = io_read_strobe_n;
        next_st.ring_prev = ring_indicator_n;
        // Ring transition to high flags a modem interrupt condition
        for (int i = 0; i < NUM_CH; i++) begin
            if (ring_indicator_n[i] & ~st.ring_prev[i]) begin
                next_st.ring_delta[i] = 1'b1; // R13
            end
        end
        // Phase keeps a held chip select from repeating an access
        unique case (st.phase)
            QUP_IDLE: begin
                if (cmb_rd | cmb_wr) begin
                    next_st.phase = QUP_ACCESS;
                end
            end
            QUP_ACCESS: begin
                next_st.phase = QUP_DONE;
            end
            QUP_DONE: begin
                if (chip_select_n) begin
                    next_st.phase = QUP_IDLE; // R19
                end
            end
            default: begin
                next_st.phase = QUP_IDLE;
            end
        endcase
        if (mode_separate) begin
            do_wr = wr_fall & ~chip_select_n; // R1
            do_rd = rd_fall & ~chip_select_n; // R17
        end else begin
            do_wr = cmb_wr;
            do_rd = cmb_rd;
        end
        if (do_wr) begin
            unique case (addr[2:0])
                OFS_IER: next_st.interrupt_enable_reg[ch] = data_in;
                OFS_MCR: next_st.modem_control_reg[ch] = data_in; // R14
                default: ;
            endcase
        end
        if (do_rd) begin
            unique case (addr[2:0])
                OFS_IER: rd_val = st.interrupt_enable_reg[ch];
                OFS_MCR: rd_val = st.modem_control_reg[ch];
                OFS_ISR: rd_val = pend[ch] ? ISR_MODEM : ISR_NONE; // R7
                OFS_MSR: begin
                    rd_val = 8'h00;
                    rd_val[MSR_RING_BIT] = ~ring_indicator_n[ch]; // R12
                    rd_val[MSR_RING_DELTA_BIT] = st.ring_delta[ch];
                end
                default: rd_val = 8'h00;
            endcase
            next_st.dout = rd_val; // R17
            next_st.doe = 1'b1;
            // Reading status clears the delta; a same-cycle new edge wins
            if ((addr[2:0] == OFS_MSR) & ~(ring_indicator_n[ch] & ~st.ring_prev[ch])) begin
                next_st.ring_delta[ch] = 1'b0;
            end
        end
        // Data drive ends with the strobe or chip select
        if (mode_separate ? io_read_strobe_n : chip_select_n) begin
            next_st.doe = 1'b0;
        end
        // Modem pins and flow control
        for (int i = 0; i < NUM_CH; i++) begin
            // Auto mode also drops request while the receiver is full
            next_st.rts_n[i] = ~next_st.modem_control_reg[i][MCR_RTS_BIT]
                | (next_st.modem_control_reg[i][MCR_AUTORTS_BIT] & rx_fifo_full[i]); // R14 R16
            // Serial gates close only in reset; framing lives outside this block
            next_st.txen[i] = 1'b1;
            next_st.rxacc[i] = rx_in[i] | ~rx_in[i];
            next_st.chint[i] = mode_separate & pend[i] & st.modem_control_reg[i][MCR_INTEN_BIT]; // R18
        end
        // Shared request pin
        if (mode_separate) begin
            next_st.irq = pend[0] & st.modem_control_reg[0][MCR_INTEN_BIT]; // R8
            next_st.irqoe = 1'b1;
        end else begin
            next_st.irq = 1'b0; // R6
            next_st.irqoe = |pend; // R4 R5 R6
        end
    end

    // ==========================================
    // Registers; the reset pin acts synchronously, since it is a plain input
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.wr_prev <= 1'b1;
            st.rd_prev <= 1'b1;
            st.ring_prev <= '1;
            st.rts_n <= '1; // R15
        end else if (pin_reset) begin
            st <= '0; // R9 R11
            st.wr_prev <= 1'b1;
            st.rd_prev <= 1'b1;
            st.ring_prev <= '1;
            st.rts_n <= '1; // R15
            st.txen <= '0; // R10
            st.rxacc <= '0; // R10
        end else begin
            st <= next_st;
        end
    end

    assign data_out = st.dout;
    assign data_oe = st.doe;
    assign rts_n = st.rts_n;
    assign tx_enable = st.txen;
    assign rx_accept = st.rxacc;
    assign irq_out = st.irq;
    assign irq_oe = st.irqoe;
    assign channel_interrupt = st.chint;

    // ==========================================
    // Checks
    sequence ring_rise_s;
        ring_indicator_n[0] && !$past(ring_indicator_n[0]);
    endsequence

    ring_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R13
        ring_rise_s |=> st.ring_delta[0])
        else $error("ring rise not flagged");
    // Pin and control bit update on the same edge, so compare them in one cycle
    rts_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R14
        !st.modem_control_reg[1][MCR_AUTORTS_BIT] |-> rts_n[1] == !st.modem_control_reg[1][MCR_RTS_BIT])
        else $error("rts does not follow control bit");
    rts_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R15
        pin_reset |=> rts_n == '1)
        else $error("rts not high after reset");
    cmb_pull_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R6
        !$past(mode_separate) |-> !irq_out)
        else $error("combined request drives high");
    cmb_merge_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R4
        (!mode_separate && |pend) |=> irq_oe)
        else $error("merged request missing");
    sep_channel_a_interrupt_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R8
        mode_separate && pend[0] && st.modem_control_reg[0][MCR_INTEN_BIT] |=> irq_out && irq_oe)
        else $error("channel A interrupt missing");
    sep_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R18
        !st.modem_control_reg[2][MCR_INTEN_BIT] |=> !channel_interrupt[2])
        else $error("interrupt not gated by control bit");
    reset_txoff_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
        pin_reset |=> tx_enable == '0 && rx_accept == '0)
        else $error("serial not disabled in reset");
    wr_store_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R1
        mode_separate && wr_fall && !chip_select_n && addr == {2'b00, OFS_IER}
            |=> st.interrupt_enable_reg[0] == $past(data_in))
        else $error("write not stored");
    ring_read_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R12
        mode_separate && rd_fall && !chip_select_n && addr == {2'b00, OFS_MSR}
            |=> data_oe && data_out[MSR_RING_BIT] == !$past(ring_indicator_n[0]))
        else $error("ring status wrong");

    // ==========================================
    // Combined bus checks; the access starts at the first select edge
    sequence cmb_start_s;
        !mode_separate && !chip_select_n && st.phase == QUP_IDLE;
    endsequence

    cmb_read_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R2 R3
        cmb_start_s ##0 io_write_strobe_n |=> data_oe)
        else $error("combined read not answered");
    cmb_write_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R2
        cmb_start_s ##0 (!io_write_strobe_n && addr == {2'b10, OFS_MCR})
            |=> st.modem_control_reg[2] == $past(data_in))
        else $error("combined write not stored");
    cmb_msr_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R7 R13
        cmb_start_s ##0 (io_write_strobe_n && addr == {2'b10, OFS_MSR})
            |=> data_out[MSR_RING_DELTA_BIT] == $past(st.ring_delta[2]))
        else $error("combined status read wrong");
    cmb_release_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R19
        !mode_separate && chip_select_n |=> !data_oe)
        else $error("data driven without select");
    irq_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R5
        !mode_separate && !(|pend) |=> !irq_oe)
        else $error("request pulled with nothing pending");

    // ==========================================
    // Separate bus and reset pin checks
    // The channel A pin is a driven level, so it must fall as well as rise
    sep_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R8
        mode_separate && !(pend[0] && st.modem_control_reg[0][MCR_INTEN_BIT]) |=> !irq_out)
        else $error("channel A pin high without cause");
    sep_rd_end_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R17
        mode_separate && io_read_strobe_n |=> !data_oe)
        else $error("data driven after read strobe");
    isr_read_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R7
        mode_separate && rd_fall && !chip_select_n && addr == {2'b00, OFS_ISR}
            |=> data_out == ($past(pend[0]) ? ISR_MODEM : ISR_NONE))
        else $error("status read wrong");
    auto_rts_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R16
        st.modem_control_reg[0][MCR_AUTORTS_BIT] && st.modem_control_reg[0][MCR_RTS_BIT] |-> rts_n[0] == $past(rx_fifo_full[0]))
        else $error("auto rts does not follow receiver");
    serial_run_a: assert property (@(posedge sys_clk) disable iff (!resetn || pin_reset) // R10
        !pin_reset |=> tx_enable == '1 && rx_accept == '1)
        else $error("serial gates closed outside reset");
    reset_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R9 R11
        pin_reset |=> !irq_oe && !irq_out && channel_interrupt == '0 && !data_oe)
        else $error("outputs not quiet in reset");
endmodule // qup_strobe_modem

// >>> verification/qup_modem_model.sv
// Modem-side partner: ring indicators, receiver-full flags and idle serial lines
`timescale 1ns/1ps
module qup_modem_model
    import qup_pkg::*;
(
    input wire logic [NUM_CH-1:0] ring_on,
    input wire logic [NUM_CH-1:0] full_on,
    output logic [NUM_CH-1:0] ring_indicator_n,
    output logic [NUM_CH-1:0] rx_fifo_full,
    output logic [NUM_CH-1:0] rx_in
);
    // ==========================================
    // Line levels
    // Ringing is shown as a low level on the ring pin
    assign ring_indicator_n = ~ring_on;
    assign rx_fifo_full = full_on;
    // Serial lines sit at the idle mark level, no frames are sent
    assign rx_in = {NUM_CH{1'b1}};
endmodule // qup_modem_model

// >>> verification/quad_uart_host_strobe_and_modem_pins_bench.sv
// Self-checking bench for the host strobe, interrupt and modem pin block
`timescale 1ns/1ps
module quad_uart_host_strobe_and_modem_pins_bench;
    import qup_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, mode_separate = 1'b1, reset_pin = 1'b0;
    logic chip_select_n = 1'b1, io_write_strobe_n = 1'b1, io_read_strobe_n = 1'b1;
    logic [ADDR_W-1:0] addr = 5'h00;
    logic [DATA_W-1:0] data_in = 8'h00, data_out, q;
    logic data_oe, irq_out, irq_oe;
    logic [NUM_CH-1:0] ring_on = 4'h0, full_on = 4'h0, ring_indicator_n, rx_in, rx_fifo_full;
    logic [NUM_CH-1:0] rts_n, tx_enable, rx_accept, channel_interrupt;
    int n_fail = 0, tests_run = 0;
    // ==========================================
    // Clock, partner and design
    always #50 sys_clk = ~sys_clk;
    qup_modem_model u_modem (.ring_on(ring_on), .full_on(full_on),
        .ring_indicator_n(ring_indicator_n), .rx_fifo_full(rx_fifo_full), .rx_in(rx_in));
    qup_strobe_modem u_dut (.sys_clk(sys_clk), .resetn(resetn), .mode_separate(mode_separate),
        .reset_pin(reset_pin), .chip_select_n(chip_select_n), .addr(addr),
        .io_write_strobe_n(io_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ring_indicator_n(ring_indicator_n), .rx_in(rx_in), .rx_fifo_full(rx_fifo_full),
        .rts_n(rts_n), .tx_enable(tx_enable), .rx_accept(rx_accept), .irq_out(irq_out),
        .irq_oe(irq_oe), .channel_interrupt(channel_interrupt));
    // ==========================================
    // Shared helpers
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    // One host access; select and direction held for the whole access, three cycles minimum
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        chip_select_n = 1'b0;
        addr = a;
        data_in = d;
        if (!mode_separate) io_write_strobe_n = ~wr;
        else if (wr) io_write_strobe_n = 1'b0;
        else io_read_strobe_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        q = data_out;
        if (!wr) chk("data_oe on", {7'h0, data_oe}, 8'h01);
        @(negedge sys_clk);
        chip_select_n = 1'b1;
        io_write_strobe_n = 1'b1;
        io_read_strobe_n = 1'b1;
        data_in = ~d; // Released bus shows no stale byte
        repeat (2) @(negedge sys_clk);
        chk("data_oe off", {7'h0, data_oe}, 8'h00);
    endtask
    task automatic ring_pulse(input int ch);
        ring_on[ch] = 1'b1;
        repeat (3) @(negedge sys_clk);
        ring_on[ch] = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic end_sim;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset_state;
        chk("rts_n", {4'h0, rts_n}, 8'h0f);
        chk("tx_enable", {4'h0, tx_enable}, 8'h0f);
        chk("rx_accept", {4'h0, rx_accept}, 8'h0f);
        $display("test reset_state done");
    endtask
    task automatic t_rts_sep;
        for (int c = 0; c < NUM_CH; c++) begin
            acc(1'b1, {c[1:0], OFS_MCR}, 8'h02);
            chk("rts_n ch", {7'h0, rts_n[c]}, 8'h00);
            acc(1'b0, {c[1:0], OFS_MCR}, 8'h00);
            chk("mcr read", q, 8'h02);
        end
        acc(1'b1, 5'h07, 8'h5a);
        acc(1'b0, 5'h07, 8'h00);
        chk("unmapped", q, 8'h00);
        acc(1'b1, {2'h0, OFS_MCR}, 8'h22);
        full_on[0] = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("auto rts full", {7'h0, rts_n[0]}, 8'h01);
        full_on[0] = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("auto rts room", {7'h0, rts_n[0]}, 8'h00);
        acc(1'b1, {2'h0, OFS_MCR}, 8'h00);
        chk("rts off", {7'h0, rts_n[0]}, 8'h01);
        $display("test rts_sep done");
    endtask
    task automatic t_ring_sep;
        acc(1'b1, {2'h0, OFS_IER}, 8'h08);
        acc(1'b1, {2'h0, OFS_MCR}, 8'h08);
        ring_on[0] = 1'b1;
        acc(1'b0, {2'h0, OFS_MSR}, 8'h00);
        chk("msr ringing", q & 8'h40, 8'h40);
        chk("no irq on fall", {7'h0, channel_interrupt[0]}, 8'h00);
        ring_on[0] = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("chan irq", {7'h0, channel_interrupt[0]}, 8'h01);
        chk("pin is chan a", {7'h0, irq_out}, {7'h0, channel_interrupt[0]});
        acc(1'b0, {2'h0, OFS_ISR}, 8'h00);
        chk("isr pending", q, ISR_MODEM);
        acc(1'b0, {2'h0, OFS_MSR}, 8'h00);
        chk("msr delta", q & 8'h44, 8'h04);
        chk("irq cleared", {7'h0, channel_interrupt[0]}, 8'h00);
        acc(1'b1, {2'h0, OFS_MCR}, 8'h00);
        ring_pulse(0);
        chk("irq gated", {7'h0, channel_interrupt[0]}, 8'h00);
        acc(1'b0, {2'h0, OFS_MSR}, 8'h00);
        $display("test ring_sep done");
    endtask
    task automatic t_pin_reset_sep;
        acc(1'b1, {2'h1, OFS_MCR}, 8'h02);
        reset_pin = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("tx off", {4'h0, tx_enable}, 8'h00);
        chk("rx off", {4'h0, rx_accept}, 8'h00);
        chk("rts reset", {4'h0, rts_n}, 8'h0f);
        reset_pin = 1'b0;
        repeat (2) @(negedge sys_clk);
        acc(1'b0, {2'h1, OFS_MCR}, 8'h00);
        chk("mcr cleared", q, MCR_RESET);
        $display("test pin_reset_sep done");
    endtask
    task automatic t_combined;
        mode_separate = 1'b0;
        reset_pin = 1'b1;
        repeat (2) @(negedge sys_clk);
        acc(1'b1, {2'h2, OFS_IER}, 8'h08);
        acc(1'b1, {2'h2, OFS_MCR}, 8'h02);
        chk("rts ch2", {7'h0, rts_n[2]}, 8'h00);
        acc(1'b0, {2'h2, OFS_MCR}, 8'h00);
        chk("mcr read", q, 8'h02);
        ring_pulse(1);
        chk("masked src", {7'h0, irq_oe}, 8'h00);
        ring_pulse(2);
        chk("irq pulled", {6'h0, irq_oe, irq_out}, 8'h02);
        acc(1'b0, {2'h2, OFS_ISR}, 8'h00);
        chk("isr ch2", q, ISR_MODEM);
        acc(1'b0, {2'h0, OFS_ISR}, 8'h00);
        chk("isr ch0", q, ISR_NONE);
        acc(1'b0, {2'h2, OFS_MSR}, 8'h00);
        chk("irq released", {6'h0, irq_oe, irq_out}, 8'h00);
        reset_pin = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("low reset", {tx_enable, rts_n}, 8'h0f);
        $display("test combined done");
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset_state();
        t_rts_sep();
        t_ring_sep();
        t_pin_reset_sep();
        t_combined();
        end_sim();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
endmodule // quad_uart_host_strobe_and_modem_pins_bench
